// file: rtl/pcst_pkg.sv
/*
  Shared constants for the transceiver configuration and self-test block:
  register map, field positions, reset values, serial frame layout, timing.
  Assumes both link ends and the bench import it.
*/
package pcst_pkg;
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int NERR = 10;
  localparam logic [15:0] REG_BASIC = 16'h0000;
  localparam logic [15:0] REG_CTL1 = 16'h0012;
  localparam logic [15:0] REG_LBCS = 16'h0013;
  localparam logic [15:0] REG_RXERR = 16'h0014;
  localparam logic [15:0] REG_CTL2 = 16'h0016;
  localparam logic [15:0] REG_CTL3 = 16'h0017;
  localparam logic [15:0] REG_CHKEN = 16'h9403;
  localparam logic [15:0] REG_CHKSRC = 16'h9407;
  localparam logic [15:0] REG_FRMH = 16'h940a;
  localparam logic [15:0] REG_FRML = 16'h940b;
  localparam logic [15:0] REG_ERRLAT0 = 16'h940c;
  localparam logic [15:0] REG_GENEN = 16'h9415;
  localparam logic [15:0] REG_GENLEN = 16'h9416;
  localparam logic [15:0] REG_GENCNT = 16'h9417;
  localparam logic [15:0] REG_GENPAY = 16'h9418;
  localparam logic [15:0] REG_GENDONE = 16'h941e;
  localparam logic [15:0] REG_MACCFG = 16'hff23;
  localparam int BC_LOOP = 14;
  localparam int BC_SPEED = 13;
  localparam int BC_ANEG = 12;
  localparam int BC_PD = 11;
  localparam int C1_AUTOX = 10;
  localparam int C1_MANX = 9;
  localparam int C1_PREFX = 8;
  localparam int C1_ENERGY_DETECT_POWERDOWN = 3;
  localparam int C1_DIAG = 2;
  localparam int LB_LD = 13;
  localparam int LB_DIG = 12;
  localparam int LB_REM = 9;
  localparam int LB_NOMAC = 8;
  localparam int LB_CABLE = 7;
  localparam int LB_TXSUP = 6;
  localparam int C2_FALLBACK = 10;
  localparam int C3_RETRY = 10;
  localparam int MC_TXDLY = 0;
  localparam int MC_RXDLY = 1;
  localparam int MC_MODE = 4;
  localparam logic [15:0] BC_RST = 16'h3000;
  localparam logic [15:0] C1_RST = 16'h0000;
  localparam logic [15:0] LB_RST = 16'h1041;
  localparam logic [15:0] C2_RST = 16'h0000;
  localparam logic [15:0] C3_RST = 16'h0c00;
  localparam logic [15:0] MC_RST = 16'h0003;
  typedef enum logic [1:0] {MAC_RGMII = 2'h0, MAC_MII = 2'h1, MAC_RMII = 2'h2} pcst_mac_t;
  typedef enum logic {LK_IDLE = 1'b0, LK_BUSY = 1'b1} pcst_lnk_t;
  localparam logic [5:0] BIT_OP = 6'h01;
  localparam logic [5:0] BIT_ADDR_END = 6'h11;
  localparam logic [5:0] BIT_TA = 6'h12;
  localparam logic [5:0] BIT_DATA0 = 6'h13;
  localparam logic [5:0] BIT_LAST = 6'h22;
  localparam logic [5:0] BIT_END = 6'h23;
  localparam int MCLK_PERIOD_NS = 5;
  localparam int MDC_PERIOD_NS = 50;
  localparam logic [3:0] MDC_HALF = 4'(MDC_PERIOD_NS / (2 * MCLK_PERIOD_NS));
  localparam logic [1:0] HR_DATA = 2'h0;
  localparam logic [1:0] HR_CMD = 2'h1;
  localparam logic [1:0] HR_STAT = 2'h2;
endpackage : pcst_pkg

// file: rtl/pcst_if.sv
/*
  Management link between controller and transceiver: clock from the
  controller, one shared data wire with a pull-up when nobody drives.
*/
`timescale 1ns/1ps
interface pcst_if;
  logic hMdc;
  logic hMdioOut;
  logic hMdioOe;
  logic dMdioOut;
  logic dMdioOe;
  logic mdio;
  assign mdio = hMdioOe ? hMdioOut : (dMdioOe ? dMdioOut : 1'b1);
  modport host (output hMdc, output hMdioOut, output hMdioOe, input mdio);
  modport dev (input hMdc, input mdio, output dMdioOut, output dMdioOe);
endinterface : pcst_if

// file: rtl/pcst_device.sv
/*
  Transceiver end: strap capture, power-down, downspeed, crossover, MAC mode,
  loopback selection, frame generator and checker, serial register slave.
  Assumes the controller makes the link clock and keeps its own duties.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: no power-down strap: attempt link after reset
// RULE2: power-down strap: wait powered down for software
// RULE3: soft power-down bit forces power-down anytime
// RULE4: downspeed after failed attempts at top speed
// RULE5: fallback enable and retry count in registers
// RULE6: energy-detect power-down when no media energy
// RULE7: crossover strap decodes four levels
// RULE8: auto resolves preferred first, manual forces
// RULE9: link ends pick preferences to suit cable
// RULE10: software overrides crossover enable and manual
// RULE11: two MAC straps select interface mode
// RULE12: change MAC mode only while powered down
// RULE13: software never selects reduced MAC mode
// RULE14: digital loopback default, suppress set, loop bit
// RULE15: cable loopback stops echo cancellation
// RULE16: line driver loopback needs loop bit
// RULE17: remote loopback, optional MAC forward, loop clear
// RULE18: generator replaces MAC data, needs diag clock
// RULE19: generator sends frames then sets done
// RULE20: checker enable and source select
// RULE21: error counter read latches all counters
// RULE22: checker counts error and odd-frame classes
module pcst_device (
  input wire logic mclk, // system clock
  input wire logic rst_b, // async reset
  pcst_if.dev lnk, // management link
  input wire logic [1:0] crossoverStrap, // strap level 0..3
  input wire logic macModeStrapHigh, // mac mode strap high
  input wire logic macModeStrapLow, // mac mode strap low
  input wire logic pdAfterResetStrap, // power-down after reset
  input wire logic downspeedStrap, // downspeed default
  input wire logic edpdStrap, // energy-detect default
  input wire logic energyDetect, // energy on media pins
  input wire logic attemptFail, // link attempt failed pulse
  input wire logic [3:0] macTxData, // mac transmit nibble
  input wire logic macTxEn, // mac transmit enable
  input wire logic macFrmEnd, // mac-side frame end pulse
  input wire logic [pcst_pkg::NERR-1:0] macFrmErr, // mac-side frame flags
  input wire logic lineFrmEnd, // line-side frame end pulse
  input wire logic [pcst_pkg::NERR-1:0] lineFrmErr, // line-side frame flags
  output logic linkAttempt_ff, // trying to bring link up
  output logic powerDown_ff, // software power-down
  output logic lowPower_ff, // energy-detect low power
  output logic speed100_ff, // high rate selected
  output logic mdix_ff, // crossover applied
  output logic [1:0] macMode_ff, // mac interface mode
  output logic rxDly_ff, // receive clock delay
  output logic txDly_ff, // transmit clock delay
  output logic digLoop_ff, // digital loopback
  output logic txSup_ff, // media transmit suppressed
  output logic cableLoop_ff, // echo cancel off
  output logic ldLoop_ff, // line driver loopback
  output logic remLoop_ff, // remote loopback
  output logic rxToMac_ff, // received data to mac
  output logic [3:0] txData_ff, // transmit nibble
  output logic txEn_ff // transmit enable
);
  import pcst_pkg::*;

  logic [2:0] mdcS_ff;
  logic [1:0] mdioS_ff;
  logic [7:0] inS1_ff;
  logic [7:0] inS2_ff;
  logic [1:0] loadCnt_ff;
  pcst_lnk_t lst_ff;
  logic [5:0] cnt_ff;
  logic [15:0] sh_ff;
  logic [15:0] addr_ff;
  logic [15:0] rdSh_ff;
  logic opRd_ff;
  logic [15:0] bc_ff, c1_ff, lb_ff, c2_ff, c3_ff, mc_ff;
  logic chkEn_ff, chkSrc_ff, genEn_ff, genPay_ff, genDone_ff;
  logic [15:0] genLen_ff, genCnt_ff, frmLeft_ff;
  logic [16:0] nibLeft_ff;
  logic [7:0] lfsr_ff;
  logic [2:0] failCnt_ff;
  logic [31:0] frmCnt_ff, frmLat_ff;
  logic [15:0] errCnt_ff [NERR];
  logic [15:0] errLat_ff [NERR];

  function automatic logic [15:0] satInc(input logic [15:0] v);
    satInc = (v == 16'hffff) ? v : v + 16'h1;
  endfunction : satInc

  function automatic logic [15:0] rdMux(input logic [15:0] a);
    logic [15:0] off;
    off = a - REG_ERRLAT0;
    rdMux = 16'h0;
    case (a)
      REG_BASIC: rdMux = bc_ff;
      REG_CTL1: rdMux = c1_ff;
      REG_LBCS: rdMux = lb_ff;
      REG_RXERR: rdMux = errCnt_ff[0];
      REG_CTL2: rdMux = c2_ff;
      REG_CTL3: rdMux = c3_ff;
      REG_CHKEN: rdMux = {15'h0, chkEn_ff};
      REG_CHKSRC: rdMux = {15'h0, chkSrc_ff};
      REG_FRMH: rdMux = frmLat_ff[31:16];
      REG_FRML: rdMux = frmLat_ff[15:0];
      REG_GENEN: rdMux = {15'h0, genEn_ff};
      REG_GENLEN: rdMux = genLen_ff;
      REG_GENCNT: rdMux = genCnt_ff;
      REG_GENPAY: rdMux = {15'h0, genPay_ff};
      REG_GENDONE: rdMux = {15'h0, genDone_ff};
      REG_MACCFG: rdMux = mc_ff;
      default: if (off < 16'(NERR - 1)) rdMux = errLat_ff[off[3:0] + 4'h1];
    endcase
  endfunction : rdMux

  // link edges and data, all seen through two flops
  wire mdcRise = mdcS_ff[1] & ~mdcS_ff[2];
  wire mdcFall = ~mdcS_ff[1] & mdcS_ff[2];
  wire mdioIn = mdioS_ff[1];
  wire busy = (lst_ff == LK_BUSY);
  wire [15:0] addrNow = {sh_ff[14:0], mdioIn};
  wire rdStb = mdcRise & busy & opRd_ff & (cnt_ff == BIT_ADDR_END);
  wire wrStb = mdcRise & busy & ~opRd_ff & (cnt_ff == BIT_LAST);
  wire drvBit = mdcFall & busy & opRd_ff & (cnt_ff >= BIT_DATA0) & (cnt_ff <= BIT_LAST);
  wire strapLoad = (loadCnt_ff == 2'h2);
  wire strapDone = (loadCnt_ff == 2'h3);
  wire [1:0] xs = inS2_ff[6:5];
  wire sHi = inS2_ff[4];
  wire sLo = inS2_ff[3];
  wire energy = inS2_ff[7];
  wire weBc = wrStb & (addr_ff == REG_BASIC);
  wire weC1 = wrStb & (addr_ff == REG_CTL1);
  wire weLb = wrStb & (addr_ff == REG_LBCS);
  wire weC2 = wrStb & (addr_ff == REG_CTL2);
  wire weC3 = wrStb & (addr_ff == REG_CTL3);
  wire weMc = wrStb & (addr_ff == REG_MACCFG);
  wire weGen = wrStb & (addr_ff == REG_GENEN);
  wire genStart = weGen & mdioIn;
  wire genStep = genEn_ff & c1_ff[C1_DIAG] & ~genStart;
  wire genActive = genStep & (frmLeft_ff != 16'h0);
  wire lastNib = (nibLeft_ff <= 17'h1);
  wire genFinish = genStep & ((frmLeft_ff == 16'h0) | (lastNib & (frmLeft_ff == 16'h1)));
  wire [1:0] strapMode = (sHi & sLo) ? MAC_RMII : ((~sHi & sLo) ? MAC_MII : MAC_RGMII);
  wire frmEnd = chkEn_ff & (chkSrc_ff ? macFrmEnd : lineFrmEnd);
  wire [NERR-1:0] frmErr = chkSrc_ff ? macFrmErr : lineFrmErr;
  wire latchCnt = rdStb & (addrNow == REG_RXERR);
  wire edpdIdle = c1_ff[C1_ENERGY_DETECT_POWERDOWN] & ~energy;
  wire downOk = bc_ff[BC_ANEG] & c2_ff[C2_FALLBACK] & speed100_ff;
  wire retryHit = ({1'b0, failCnt_ff} + 4'h1) >= {1'b0, c3_ff[C3_RETRY+:3]};
  wire lbOn = bc_ff[BC_LOOP];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mdcS_ff <= 3'h0;
      mdioS_ff <= 2'h3;
      inS1_ff <= 8'h0;
      inS2_ff <= 8'h0;
      loadCnt_ff <= 2'h0;
    end else begin
      mdcS_ff <= {mdcS_ff[1:0], lnk.hMdc};
      mdioS_ff <= {mdioS_ff[0], lnk.mdio};
      inS1_ff <= {energyDetect, crossoverStrap, macModeStrapHigh, macModeStrapLow,
                  pdAfterResetStrap, downspeedStrap, edpdStrap};
      inS2_ff <= inS1_ff;
      if (!strapDone) loadCnt_ff <= loadCnt_ff + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lst_ff <= LK_IDLE;
      cnt_ff <= 6'h0;
      sh_ff <= 16'h0;
      opRd_ff <= 1'b0;
      addr_ff <= 16'h0;
    end else if (mdcRise) begin
      unique case (lst_ff)
        LK_IDLE: if (!mdioIn) begin
          lst_ff <= LK_BUSY;
          cnt_ff <= BIT_OP;
        end
        LK_BUSY: begin
          sh_ff <= addrNow;
          if (cnt_ff == BIT_OP) opRd_ff <= mdioIn;
          if (cnt_ff == BIT_ADDR_END) addr_ff <= addrNow;
          if (cnt_ff != BIT_END) cnt_ff <= cnt_ff + 6'h1;
        end
      endcase
    end else if (mdcFall && busy && cnt_ff == BIT_END) begin
      lst_ff <= LK_IDLE;
      cnt_ff <= 6'h0;
    end
  end

  // data changes only on falling link clock, so the far end samples a settled bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdSh_ff <= 16'h0;
      lnk.dMdioOut <= 1'b1;
      lnk.dMdioOe <= 1'b0;
    end else if (rdStb) begin
      rdSh_ff <= rdMux(addrNow);
    end else if (drvBit) begin
      lnk.dMdioOe <= 1'b1;
      lnk.dMdioOut <= rdSh_ff[15];
      rdSh_ff <= {rdSh_ff[14:0], 1'b0};
    end else if (mdcFall) begin
      lnk.dMdioOe <= 1'b0;
    end
  end

  // straps land once, after synchronising; software may rewrite any of it later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bc_ff <= BC_RST;
      c1_ff <= C1_RST;
      c2_ff <= C2_RST;
      mc_ff <= MC_RST;
    end else if (strapLoad) begin
      bc_ff[BC_PD] <= inS2_ff[2]; // RULE2
      c1_ff[C1_AUTOX] <= xs[1]; // RULE7
      c1_ff[C1_MANX] <= (xs == 2'h1); // RULE7
      c1_ff[C1_PREFX] <= (xs == 2'h2); // RULE7
      c1_ff[C1_ENERGY_DETECT_POWERDOWN] <= inS2_ff[0];
      c2_ff[C2_FALLBACK] <= inS2_ff[1];
      mc_ff[MC_MODE+:2] <= strapMode; // RULE11
      mc_ff[MC_RXDLY] <= ~sLo; // RULE11
      mc_ff[MC_TXDLY] <= ~sHi & ~sLo; // RULE11
    end else begin
      if (weBc) bc_ff <= addrNow; // RULE3
      if (weC1) c1_ff <= addrNow; // RULE10
      if (weC2) c2_ff <= addrNow; // RULE5
      if (weMc) mc_ff <= addrNow;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lb_ff <= LB_RST; // RULE14
      c3_ff <= C3_RST;
      chkEn_ff <= 1'b0;
      chkSrc_ff <= 1'b0;
      genLen_ff <= 16'h0;
      genCnt_ff <= 16'h0;
      genPay_ff <= 1'b0;
    end else begin
      if (weLb) lb_ff <= addrNow;
      if (weC3) c3_ff <= addrNow; // RULE5
      if (wrStb && addr_ff == REG_CHKEN) chkEn_ff <= mdioIn; // RULE20
      if (wrStb && addr_ff == REG_CHKSRC) chkSrc_ff <= mdioIn; // RULE20
      if (wrStb && addr_ff == REG_GENLEN) genLen_ff <= addrNow;
      if (wrStb && addr_ff == REG_GENCNT) genCnt_ff <= addrNow;
      if (wrStb && addr_ff == REG_GENPAY) genPay_ff <= mdioIn;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      genEn_ff <= 1'b0;
      genDone_ff <= 1'b0;
      frmLeft_ff <= 16'h0;
      nibLeft_ff <= 17'h0;
      lfsr_ff <= 8'h01;
    end else begin
      if (weGen) genEn_ff <= mdioIn;
      else if (genFinish) genEn_ff <= 1'b0; // RULE19
      if (genFinish) genDone_ff <= 1'b1; // RULE19
      else if (genStart) genDone_ff <= 1'b0;
      if (genStart) begin
        frmLeft_ff <= genCnt_ff;
        nibLeft_ff <= {genLen_ff, 1'b0};
      end else if (genActive) begin // RULE19
        lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
        nibLeft_ff <= lastNib ? {genLen_ff, 1'b0} : nibLeft_ff - 17'h1;
        if (lastNib) frmLeft_ff <= frmLeft_ff - 16'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frmCnt_ff <= 32'h0;
      frmLat_ff <= 32'h0;
      for (int i = 0; i < NERR; i++) begin
        errCnt_ff[i] <= 16'h0;
        errLat_ff[i] <= 16'h0;
      end
    end else begin
      if (frmEnd) frmCnt_ff <= frmCnt_ff + 32'h1; // RULE20
      if (latchCnt) frmLat_ff <= frmCnt_ff; // RULE21
      for (int i = 0; i < NERR; i++) begin
        if (frmEnd && frmErr[i]) errCnt_ff[i] <= satInc(errCnt_ff[i]); // RULE22
        if (latchCnt) errLat_ff[i] <= errCnt_ff[i]; // RULE21
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      linkAttempt_ff <= 1'b0;
      powerDown_ff <= 1'b1;
      lowPower_ff <= 1'b0;
      speed100_ff <= 1'b1;
      failCnt_ff <= 3'h0;
      mdix_ff <= 1'b0;
    end else begin
      powerDown_ff <= ~strapDone | bc_ff[BC_PD]; // RULE3
      lowPower_ff <= edpdIdle; // RULE6
      linkAttempt_ff <= strapDone & ~bc_ff[BC_PD] & ~edpdIdle; // RULE1
      if (!linkAttempt_ff) begin
        speed100_ff <= bc_ff[BC_SPEED];
        failCnt_ff <= 3'h0;
        mdix_ff <= c1_ff[C1_AUTOX] ? c1_ff[C1_PREFX] : c1_ff[C1_MANX]; // RULE8
      end else begin
        if (attemptFail && downOk) begin // RULE4
          failCnt_ff <= failCnt_ff + 3'h1;
          if (retryHit) speed100_ff <= 1'b0;
        end
        if (!c1_ff[C1_AUTOX]) mdix_ff <= c1_ff[C1_MANX]; // RULE8
        else if (attemptFail) mdix_ff <= ~mdix_ff; // RULE8
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      macMode_ff <= MAC_RGMII;
      rxDly_ff <= 1'b1;
      txDly_ff <= 1'b1;
      digLoop_ff <= 1'b0;
      txSup_ff <= 1'b0;
      cableLoop_ff <= 1'b0;
      ldLoop_ff <= 1'b0;
      remLoop_ff <= 1'b0;
      rxToMac_ff <= 1'b1;
      txData_ff <= 4'h0;
      txEn_ff <= 1'b0;
    end else begin
      macMode_ff <= mc_ff[MC_MODE+:2];
      rxDly_ff <= mc_ff[MC_RXDLY];
      txDly_ff <= mc_ff[MC_TXDLY];
      digLoop_ff <= lbOn & lb_ff[LB_DIG] & ~lb_ff[LB_LD]; // RULE14
      txSup_ff <= lbOn & lb_ff[LB_DIG] & lb_ff[LB_TXSUP]; // RULE14
      cableLoop_ff <= lb_ff[LB_CABLE]; // RULE15
      ldLoop_ff <= lbOn & lb_ff[LB_LD]; // RULE16
      remLoop_ff <= ~lbOn & lb_ff[LB_REM]; // RULE17
      rxToMac_ff <= ~(~lbOn & lb_ff[LB_REM] & lb_ff[LB_NOMAC]); // RULE17
      txData_ff <= genEn_ff ? (genPay_ff ? 4'hf : lfsr_ff[3:0]) : macTxData; // RULE18
      txEn_ff <= genEn_ff ? genActive : macTxEn; // RULE18
    end
  end
endmodule : pcst_device

// file: rtl/pcst_host.sv
/*
  Controller end: turns register-port commands into serial management frames
  and makes the link clock by dividing mclk. Assumes one frame at a time.
*/
`timescale 1ns/1ps
module pcst_host (
  input wire logic mclk, // system clock
  input wire logic rst_b, // async reset
  pcst_if.host lnk, // management link
  input wire logic [1:0] regAddr, // register index
  input wire logic [31:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [31:0] regRdData_ff // read data, cycle after strobe
);
  import pcst_pkg::*;

  pcst_lnk_t st_ff;
  logic [3:0] div_ff;
  logic [5:0] idx_ff;
  logic [34:0] frm_ff;
  logic rdOp_ff;
  logic [15:0] data_ff;
  logic pdShadow_ff;
  logic refused_ff;
  logic [1:0] mdioS_ff;

  wire cmdWr = regWr & (regAddr == HR_CMD);
  wire cmdRd = regWrData[16];
  wire [15:0] cmdAddr = regWrData[15:0];
  wire toMac = ~cmdRd & (cmdAddr == REG_MACCFG);
  // refuse mode changes unless powered down, and never choose the reduced mode
  wire badMac = toMac & (~pdShadow_ff | (data_ff[MC_MODE+:2] == MAC_RMII)); // RULE12 RULE13
  wire go = cmdWr & (st_ff == LK_IDLE) & ~badMac;
  wire halfDone = (st_ff == LK_BUSY) & (div_ff == MDC_HALF - 4'h1);
  wire hFall = halfDone & lnk.hMdc;
  wire [5:0] nxtIdx = idx_ff + 6'h1;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= LK_IDLE;
      div_ff <= 4'h0;
      idx_ff <= 6'h0;
      frm_ff <= 35'h0;
      rdOp_ff <= 1'b0;
      lnk.hMdc <= 1'b0;
      lnk.hMdioOut <= 1'b1;
      lnk.hMdioOe <= 1'b0;
    end else begin
      unique case (st_ff)
        LK_IDLE: if (go) begin
          st_ff <= LK_BUSY;
          frm_ff <= {1'b0, cmdRd, cmdAddr, 1'b1, cmdRd ? 16'hffff : data_ff};
          rdOp_ff <= cmdRd;
          div_ff <= 4'h0;
          idx_ff <= 6'h0;
          lnk.hMdioOut <= 1'b0;
          lnk.hMdioOe <= 1'b1;
        end
        LK_BUSY: if (!halfDone) begin
          div_ff <= div_ff + 4'h1;
        end else begin
          div_ff <= 4'h0;
          lnk.hMdc <= ~lnk.hMdc;
          if (lnk.hMdc && idx_ff == BIT_LAST) begin
            st_ff <= LK_IDLE;
            lnk.hMdioOe <= 1'b0;
            lnk.hMdioOut <= 1'b1;
          end else if (lnk.hMdc) begin
            idx_ff <= nxtIdx;
            frm_ff <= {frm_ff[33:0], 1'b0};
            lnk.hMdioOut <= frm_ff[33];
            lnk.hMdioOe <= ~(rdOp_ff & (nxtIdx >= BIT_TA));
          end
        end
      endcase
    end
  end

  // sample just before dropping the clock: the far end has had a whole period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mdioS_ff <= 2'h3;
      data_ff <= 16'h0;
      pdShadow_ff <= 1'b0;
      refused_ff <= 1'b0;
      regRdData_ff <= 32'h0;
    end else begin
      mdioS_ff <= {mdioS_ff[0], lnk.mdio};
      if (regWr && regAddr == HR_DATA) data_ff <= regWrData[15:0];
      else if (hFall && rdOp_ff && idx_ff >= BIT_DATA0) data_ff <= {data_ff[14:0], mdioS_ff[1]};
      if (go && !cmdRd && cmdAddr == REG_BASIC) pdShadow_ff <= data_ff[BC_PD];
      if (cmdWr) refused_ff <= ~go;
      if (!regRd) regRdData_ff <= 32'h0;
      else if (regAddr == HR_DATA) regRdData_ff <= {16'h0, data_ff};
      else if (regAddr == HR_STAT) regRdData_ff <= {30'h0, refused_ff, st_ff == LK_BUSY};
      else regRdData_ff <= 32'h0;
    end
  end
endmodule : pcst_host

// file: test/pcst_checker.sv
/*
  Protocol checker for the management wire between the two ends.
  Assumes it sits in the mclk domain and watches the pcst_if signals as plain inputs.
*/
`timescale 1ns/1ps
module pcst_checker (
  input wire logic mclk, // system clock
  input wire logic rst_b, // async reset
  input wire logic hMdc, // link clock
  input wire logic hMdioOut, // host data
  input wire logic hMdioOe, // host enable
  input wire logic dMdioOut, // device data
  input wire logic dMdioOe, // device enable
  input wire logic mdio // resolved wire
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [7:0] devRun_ff;
  // length of one device drive burst, 16 data bits of ten mclk each
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) devRun_ff <= 8'h00;
    else devRun_ff <= dMdioOe ? devRun_ff + 8'h01 : 8'h00;
  end
  AST_NO_FIGHT: assert property (!(hMdioOe && dMdioOe)) else $error("both ends drive");
  AST_MDC_HIGH: assert property ($rose(hMdc) |-> hMdc [*5] ##1 !hMdc) else $error("bad high half");
  AST_MDC_LOW: assert property ($fell(hMdc) |-> !hMdc [*5]) else $error("short low half");
  AST_HOST_HOLD: assert property (hMdioOe && hMdc && $past(hMdc) |-> $stable(hMdioOut))
    else $error("host data moved");
  AST_START_LOW: assert property ($rose(hMdioOe) |-> !hMdioOut) else $error("no start bit");
  AST_DEV_START: assert property ($rose(dMdioOe) |-> !hMdc) else $error("device drove on high clock");
  AST_DEV_HOLD: assert property (dMdioOe && hMdc && $past(hMdc) |-> $stable(dMdioOut))
    else $error("device data moved");
  AST_DEV_SPAN: assert property ($fell(dMdioOe) |-> devRun_ff inside {[8'h96:8'haf]})
    else $error("bad drive span");
  cover property ($rose(hMdioOe));
  cover property ($fell(dMdioOe));
  cover property ($fell(mdio) && !hMdioOe);
endmodule : pcst_checker

// file: test/phy_config_loopback_selftest_tb.sv
/*
  Bench: both ends joined over pcst_if, driven through the host register port.
  Assumes pcst_pkg, pcst_if and both ends are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module phy_config_loopback_selftest_tb;
  import pcst_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, pd = 1'b0, eDet = 1'b0;
  logic aFail = 1'b0, mEnd = 1'b0, lEnd = 1'b0, mEn = 1'b1, genSeen = 1'b0, st;
  logic [1:0] regAddr = 2'h0, cx = 2'h0, mode;
  logic [31:0] regWrData = 32'h0, regRdData_ff, rd;
  logic [3:0] mDat = 4'h5, txDat;
  logic [NERR-1:0] fErr = '0;
  logic [15:0] d;
  logic lnkA, pwrD, lowP, spd, mdix, rxD, txD, dig, sup, cab, ld, rem, toMac, txEn;
  int fail_count = 0, cmp_count = 0;
  // {basic, loop reg, expected {dig,sup,cab,ld,rem,toMac}, mask}
  logic [43:0] lbT [7] = '{44'h3000_1041_020, 44'h7000_1041_c3e, 44'h7000_1001_83e, 44'h7000_2000_12e,
    44'h3000_0080_22e, 44'h3000_0241_0ef, 44'h3000_0341_0af};
  pcst_if lnk();
  pcst_host u_pcst_host (.mclk(mclk), .rst_b(rst_b), .lnk(lnk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff));
  pcst_device u_pcst_device (.mclk(mclk), .rst_b(rst_b), .lnk(lnk), .crossoverStrap(cx),
    .macModeStrapHigh(cx[1]), .macModeStrapLow(cx[0]), .pdAfterResetStrap(pd), .downspeedStrap(1'b0),
    .edpdStrap(1'b0), .energyDetect(eDet), .attemptFail(aFail), .macTxData(mDat), .macTxEn(mEn),
    .macFrmEnd(mEnd), .macFrmErr(fErr), .lineFrmEnd(lEnd), .lineFrmErr(fErr), .linkAttempt_ff(lnkA),
    .powerDown_ff(pwrD), .lowPower_ff(lowP), .speed100_ff(spd), .mdix_ff(mdix), .macMode_ff(mode),
    .rxDly_ff(rxD), .txDly_ff(txD), .digLoop_ff(dig), .txSup_ff(sup), .cableLoop_ff(cab), .ldLoop_ff(ld),
    .remLoop_ff(rem), .rxToMac_ff(toMac), .txData_ff(txDat), .txEn_ff(txEn));
  pcst_checker u_pcst_checker (.mclk(mclk), .rst_b(rst_b), .hMdc(lnk.hMdc), .hMdioOut(lnk.hMdioOut),
    .hMdioOe(lnk.hMdioOe), .dMdioOut(lnk.dMdioOut), .dMdioOe(lnk.dMdioOe), .mdio(lnk.mdio));
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) if (txEn === 1'b1 && txDat === 4'hf) genSeen <= 1'b1;
  task automatic conclude;
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // one port cycle; read data is taken in the cycle after the strobe
  task automatic acc(input logic [1:0] a, input logic [31:0] v, input logic w);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWr <= w;
    regRd <= !w;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge mclk);
    rd = regRdData_ff;
  endtask : acc
  task automatic op(input logic [15:0] a, input logic [15:0] v, input logic r);
    int i;
    if (!r) acc(HR_DATA, {16'h0, v}, 1'b1);
    acc(HR_CMD, {15'h0, r, a}, 1'b1);
    for (i = 0; i < 200; i++) begin
      acc(HR_STAT, 32'h0, 1'b0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 200) begin
      fail_count++;
      conclude();
    end
    st = rd[1];
    if (r) acc(HR_DATA, 32'h0, 1'b0);
    d = rd[15:0];
    // device applies a write a few cycles after the last link bit
    repeat (8) @(posedge mclk);
  endtask : op
  task automatic rchk(input logic [15:0] a, input logic [15:0] e, input string n);
    op(a, 16'h0, 1'b1);
    `CHK(n, e, d)
  endtask : rchk
  task automatic pls(input logic [1:0] k, input logic [NERR-1:0] e);
    @(posedge mclk);
    {aFail, mEnd, lEnd} <= 3'b100 >> k;
    fErr <= e;
    @(posedge mclk);
    {aFail, mEnd, lEnd} <= 3'h0;
    repeat (4) @(posedge mclk);
  endtask : pls
  task automatic rst(input logic [2:0] s);
    @(posedge mclk);
    rst_b <= 1'b0;
    {pd, cx} <= s;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : rst
  initial begin
    for (int s = 0; s < 4; s++) begin
      rst(3'(s));
      `CHK("mdix", (s == 1 || s == 2), mdix)
      `CHK("run", 2'b10, {lnkA, pwrD})
      `CHK("mode", (cx[0] ? (cx[1] ? MAC_RMII : MAC_MII) : MAC_RGMII), mode)
      `CHK("dly", {!cx[0], !cx}, {rxD, txD})
    end
    pls(2'h0, '0);
    `CHK("auto", 1'b1, mdix)
    rst(3'b100);
    `CHK("hold", 2'b01, {lnkA, pwrD})
    rchk(REG_LBCS, LB_RST, "lbcs");
    rchk(REG_CTL3, C3_RST, "retry");
    rchk(REG_MACCFG, MC_RST, "maccfg");
    rchk(16'h1234, 16'h0000, "unmapped");
    // the controller only trusts a power-down it has written itself
    op(REG_BASIC, 16'h3800, 1'b0);
    op(REG_MACCFG, 16'h0010, 1'b0);
    `CHK("mac", {MAC_MII, 2'b00}, {mode, rxD, txD})
    op(REG_MACCFG, 16'h0020, 1'b0);
    `CHK("reduced", {1'b1, MAC_MII}, {st, mode})
    op(REG_BASIC, 16'h3000, 1'b0);
    `CHK("release", 3'b101, {lnkA, pwrD, spd})
    op(REG_MACCFG, 16'h0003, 1'b0);
    `CHK("locked", {1'b1, MAC_MII, 2'b00}, {st, mode, rxD, txD})
    op(REG_CTL2, 16'h0400, 1'b0);
    op(REG_CTL3, 16'h0400, 1'b0);
    pls(2'h0, '0);
    `CHK("speed", 1'b0, spd)
    op(REG_CTL1, 16'h020c, 1'b0);
    `CHK("override", 2'b11, {mdix, lowP})
    eDet <= 1'b1;
    pls(2'h0, '0);
    `CHK("energy", 2'b10, {mdix, lowP})
    op(REG_CTL1, 16'h0000, 1'b0);
    `CHK("mdi", 1'b0, mdix)
    foreach (lbT[i]) begin
      op(REG_BASIC, lbT[i][43:28], 1'b0);
      op(REG_LBCS, lbT[i][27:12], 1'b0);
      `CHK("loop", lbT[i][11:6] & lbT[i][5:0], {dig,sup,cab,ld,rem,toMac} & lbT[i][5:0])
    end
    op(REG_LBCS, 16'h0000, 1'b0);
    `CHK("mactx", 5'h15, {txEn, txDat})
    op(REG_GENLEN, 16'h0002, 1'b0);
    op(REG_GENCNT, 16'h0001, 1'b0);
    op(REG_GENPAY, 16'h0001, 1'b0);
    op(REG_GENEN, 16'h0001, 1'b0);
    rchk(REG_GENDONE, 16'h0000, "nodiag");
    op(REG_CTL1, 16'h0004, 1'b0);
    rchk(REG_GENDONE, 16'h0001, "done");
    `CHK("gendata", 1'b1, genSeen)
    rchk(REG_GENEN, 16'h0000, "genoff");
    op(REG_CHKEN, 16'h0001, 1'b0);
    op(REG_CHKSRC, 16'h0001, 1'b0);
    pls(2'h1, 10'h001);
    pls(2'h1, 10'h003);
    pls(2'h1, 10'h040);
    pls(2'h2, 10'h001);
    pls(2'h2, 10'h001);
    rchk(REG_RXERR, 16'h0002, "crc");
    pls(2'h1, 10'h000);
    rchk(REG_FRMH, 16'h0000, "frmh");
    rchk(REG_FRML, 16'h0003, "frml");
    rchk(REG_ERRLAT0, 16'h0001, "lenerr");
    rchk(REG_ERRLAT0 + 16'h0005, 16'h0001, "oddnib");
    op(REG_BASIC, 16'h3800, 1'b0);
    `CHK("softpd", 2'b01, {lnkA, pwrD})
    conclude();
  end
endmodule : phy_config_loopback_selftest_tb
